// ### design/dwell_tick.sv
`timescale 1ns/1ps
// 10 ms tick enable divider
module dwell_tick #(
   parameter int unsigned CYCLES = list_seq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic run,
   output logic tick
);
   localparam int unsigned W = list_seq_pkg::TICK_W;
   initial
   begin
      if (CYCLES < 1 || CYCLES >= (1 << W))
      begin
         $error("dwell_tick: CYCLES out of range");
      end
   end
   logic [W-1:0] cnt_r;
   // free count while running, restart when idle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt_r <= '0;
         tick <= 1'b0;
      end
      else if (cnt_r == W'(CYCLES - 1))
      begin
         cnt_r <= '0;
         tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// ### design/list_seq_pkg.sv
package list_seq_pkg;
   // table geometry
   localparam int unsigned TABLE_DEPTH = 250;
   localparam int unsigned PTR_W = 8;
   localparam int unsigned VAL_W = 16;
   localparam int unsigned DWELL_W = 16;
   localparam int unsigned QUERY_SPAN = 16;
   // dwell unit: 10 ms at 125 MHz
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned DWELL_UNIT_MS = 10;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * DWELL_UNIT_MS;
   localparam int unsigned TICK_W = 21;
   // error codes, magnitude of the negative number
   localparam logic [9:0] ERR_NONE = 10'h000;
   localparam logic [9:0] ERR_CONFLICT = 10'h0DD; // -221
   localparam logic [9:0] ERR_LEN = 10'h0E2; // -226
   // reset values
   localparam logic [15:0] COUNT_RST = 16'h0001;
   localparam logic [PTR_W-1:0] PTR_ZERO = 8'h00;
   localparam logic DIR_UP = 1'b1;
   localparam logic DIR_DOWN = 1'b0;
   localparam logic [DWELL_W-1:0] DWELL_MIN = 16'h0001;
   // host commands
   typedef enum logic [3:0] {
      CMD_NOP,
      CMD_CLEAR,
      CMD_CURR_APPEND,
      CMD_DWELL_APPEND,
      CMD_RELAY_APPEND,
      CMD_VOLT_APPEND,
      CMD_SET_COUNT,
      CMD_SET_SKIP,
      CMD_SET_DIR,
      CMD_SET_QSTART,
      CMD_SET_CONT,
      CMD_QUERY_CURR,
      CMD_QUERY_CURR_PTR,
      CMD_RUN,
      CMD_FIXED
   } cmd_e;
endpackage

// ### design/output_list_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - erase zeroes pointers, selects ascending order
// - continuous trigger query returns enable flag
// - relay follows step control value when assigned
// - relay query reports energized state
// - no relay points: refuse run, error -226
// - repetition count 0..65535, reported on query
// - count zero repeats until fixed mode
// - skip first steps after first pass
// - erase also zeroes skip value
// - skipping only in ascending order
// - current values append; 250 entries maximum
// - single current entry used every step
// - current query streams up to 16 values
// - voltage entries present: query posts -221
// - current pointer counts points, next location
// - ascending first-to-last, descending last-to-first
// - direction query: 1 ascending, 0 descending
// - per-location dwell holds each step
// - single dwell entry used every step
// - reset disables continuous; rearm after trigger
module output_list_sequencer #(
   parameter int unsigned DEPTH = list_seq_pkg::TABLE_DEPTH,
   parameter int unsigned TICK_CYCLES = list_seq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host command port, data already converted to binary
   input wire logic cmd_valid,
   input wire list_seq_pkg::cmd_e cmd_code,
   input wire logic [15:0] cmd_data,
   // trigger and relay assignment
   input wire logic trigger,
   input wire logic relay_assign_list,
   // output set point and relay
   output logic [list_seq_pkg::VAL_W-1:0] setpoint,
   output logic relay_on,
   output logic running,
   // settings readback
   output logic cont_enable,
   output logic wait_trigger,
   output logic dir_up,
   output logic [15:0] repetition_count,
   output logic [list_seq_pkg::PTR_W-1:0] preamble_skip_steps,
   output logic [list_seq_pkg::PTR_W-1:0] current_pointer_query,
   output logic [list_seq_pkg::PTR_W-1:0] relay_point_count_query,
   output logic [list_seq_pkg::PTR_W-1:0] query_start_location,
   // query answer stream
   output logic resp_valid,
   output logic resp_last,
   output logic [list_seq_pkg::VAL_W-1:0] resp_data,
   // error queue entry, one-cycle pulse
   output logic err_valid,
   output logic [9:0] err_code
);
   localparam int unsigned PW = list_seq_pkg::PTR_W;
   initial
   begin
      if (DEPTH < 1 || DEPTH > 255)
      begin
         $error("output_list_sequencer: DEPTH out of range");
      end
   end

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOAD,
      ST_HOLD
   } seq_e;

   logic [list_seq_pkg::VAL_W-1:0] curr_mem [DEPTH];
   logic [list_seq_pkg::DWELL_W-1:0] dwell_mem [DEPTH];
   logic relay_mem [DEPTH];
   logic [PW-1:0] dwell_ptr_r;
   logic [PW-1:0] volt_ptr_r;
   logic [PW-1:0] step_r;
   logic [15:0] pass_r;
   logic [list_seq_pkg::DWELL_W-1:0] dwell_r;
   logic [PW-1:0] q_idx_r;
   logic [4:0] q_left_r;
   logic q_busy_r;
   seq_e st_r;
   logic tick;
   logic is_cmd;

   assign is_cmd = cmd_valid;

   dwell_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .rst(rst),
      .run(st_r == ST_HOLD),
      .tick(tick)
   );

   // table storage, no reset on contents
   always_ff @(posedge clk)
   begin
      if (is_cmd && cmd_code == list_seq_pkg::CMD_CURR_APPEND && current_pointer_query < PW'(DEPTH))
      begin
         curr_mem[current_pointer_query] <= cmd_data;
      end
      if (is_cmd && cmd_code == list_seq_pkg::CMD_DWELL_APPEND && dwell_ptr_r < PW'(DEPTH))
      begin
         dwell_mem[dwell_ptr_r] <= cmd_data;
      end
      if (is_cmd && cmd_code == list_seq_pkg::CMD_RELAY_APPEND && relay_point_count_query < PW'(DEPTH))
      begin
         relay_mem[relay_point_count_query] <= cmd_data[0];
      end
   end

   // table pointers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         current_pointer_query <= list_seq_pkg::PTR_ZERO;
         dwell_ptr_r <= list_seq_pkg::PTR_ZERO;
         relay_point_count_query <= list_seq_pkg::PTR_ZERO;
         volt_ptr_r <= list_seq_pkg::PTR_ZERO;
      end
      else if (is_cmd && cmd_code == list_seq_pkg::CMD_CLEAR)
      begin
         current_pointer_query <= list_seq_pkg::PTR_ZERO;
         dwell_ptr_r <= list_seq_pkg::PTR_ZERO;
         relay_point_count_query <= list_seq_pkg::PTR_ZERO;
         volt_ptr_r <= list_seq_pkg::PTR_ZERO;
      end
      else if (is_cmd && st_r == ST_IDLE)
      begin
         unique case (cmd_code)
            list_seq_pkg::CMD_CURR_APPEND:
               if (current_pointer_query < PW'(DEPTH))
               begin
                  current_pointer_query <= current_pointer_query + 1'b1;
               end
            list_seq_pkg::CMD_DWELL_APPEND:
               if (dwell_ptr_r < PW'(DEPTH))
               begin
                  dwell_ptr_r <= dwell_ptr_r + 1'b1;
               end
            list_seq_pkg::CMD_RELAY_APPEND:
               if (relay_point_count_query < PW'(DEPTH))
               begin
                  relay_point_count_query <= relay_point_count_query + 1'b1;
               end
            list_seq_pkg::CMD_VOLT_APPEND:
               if (volt_ptr_r < PW'(DEPTH))
               begin
                  volt_ptr_r <= volt_ptr_r + 1'b1;
               end
            default:
            begin
            end
         endcase
      end
   end

   // list settings
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dir_up <= list_seq_pkg::DIR_UP;
         repetition_count <= list_seq_pkg::COUNT_RST;
         preamble_skip_steps <= list_seq_pkg::PTR_ZERO;
         query_start_location <= list_seq_pkg::PTR_ZERO;
      end
      else if (is_cmd)
      begin
         unique case (cmd_code)
            list_seq_pkg::CMD_CLEAR:
            begin
               dir_up <= list_seq_pkg::DIR_UP;
               preamble_skip_steps <= list_seq_pkg::PTR_ZERO;
            end
            list_seq_pkg::CMD_SET_DIR:
               dir_up <= cmd_data[0];
            list_seq_pkg::CMD_SET_COUNT:
               repetition_count <= cmd_data;
            list_seq_pkg::CMD_SET_SKIP:
               if (cmd_data <= 16'(DEPTH))
               begin
                  preamble_skip_steps <= cmd_data[PW-1:0];
               end
            list_seq_pkg::CMD_SET_QSTART:
               if (cmd_data <= 16'(DEPTH))
               begin
                  query_start_location <= cmd_data[PW-1:0];
               end
            default:
            begin
            end
         endcase
      end
   end

   // continuous trigger flag and armed status
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cont_enable <= 1'b0;
         wait_trigger <= 1'b0;
      end
      else
      begin
         if (is_cmd && cmd_code == list_seq_pkg::CMD_SET_CONT)
         begin
            cont_enable <= cmd_data[0];
         end
         if (cont_enable || (is_cmd && cmd_code == list_seq_pkg::CMD_SET_CONT && cmd_data[0]))
         begin
            wait_trigger <= 1'b1;
         end
         else if (trigger)
         begin
            wait_trigger <= 1'b0;
         end
      end
   end

   // step sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= ST_IDLE;
         step_r <= list_seq_pkg::PTR_ZERO;
         pass_r <= 16'h0000;
         dwell_r <= list_seq_pkg::DWELL_MIN;
         setpoint <= '0;
         relay_on <= 1'b0;
         running <= 1'b0;
      end
      else if (is_cmd && (cmd_code == list_seq_pkg::CMD_FIXED || cmd_code == list_seq_pkg::CMD_CLEAR))
      begin
         st_r <= ST_IDLE;
         running <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            ST_IDLE:
               if (is_cmd && cmd_code == list_seq_pkg::CMD_RUN && relay_point_count_query != '0
                   && current_pointer_query != '0)
               begin
                  st_r <= ST_LOAD;
                  running <= 1'b1;
                  pass_r <= 16'h0001;
                  step_r <= dir_up ? list_seq_pkg::PTR_ZERO : current_pointer_query - 1'b1;
               end
            ST_LOAD:
            begin
               setpoint <= (current_pointer_query == 8'h01) ? curr_mem[0] : curr_mem[step_r];
               dwell_r <= (dwell_ptr_r <= 8'h01) ? dwell_mem[0] : dwell_mem[step_r];
               if (relay_assign_list)
               begin
                  relay_on <= (relay_point_count_query == 8'h01) ? relay_mem[0] : relay_mem[step_r];
               end
               st_r <= ST_HOLD;
            end
            ST_HOLD:
               if (tick)
               begin
                  if (dwell_r > list_seq_pkg::DWELL_MIN)
                  begin
                     dwell_r <= dwell_r - 1'b1;
                  end
                  else if (dir_up && step_r + 1'b1 < current_pointer_query)
                  begin
                     step_r <= step_r + 1'b1;
                     st_r <= ST_LOAD;
                  end
                  else if (!dir_up && step_r != '0)
                  begin
                     step_r <= step_r - 1'b1;
                     st_r <= ST_LOAD;
                  end
                  else if (repetition_count != 16'h0000 && pass_r >= repetition_count)
                  begin
                     st_r <= ST_IDLE;
                     running <= 1'b0;
                  end
                  else
                  begin
                     pass_r <= pass_r + 1'b1;
                     st_r <= ST_LOAD;
                     if (!dir_up)
                     begin
                        step_r <= current_pointer_query - 1'b1;
                     end
                     else if (preamble_skip_steps < current_pointer_query)
                     begin
                        step_r <= preamble_skip_steps;
                     end
                     else
                     begin
                        step_r <= current_pointer_query - 1'b1;
                     end
                  end
               end
            default:
               st_r <= ST_IDLE;
         endcase
      end
   end

   // current table query stream
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q_busy_r <= 1'b0;
         q_idx_r <= list_seq_pkg::PTR_ZERO;
         q_left_r <= '0;
         resp_valid <= 1'b0;
         resp_last <= 1'b0;
         resp_data <= '0;
      end
      else if (!q_busy_r)
      begin
         resp_valid <= 1'b0;
         resp_last <= 1'b0;
         if (is_cmd && cmd_code == list_seq_pkg::CMD_QUERY_CURR
             && query_start_location < current_pointer_query)
         begin
            q_busy_r <= 1'b1;
            q_idx_r <= query_start_location;
            q_left_r <= 5'(list_seq_pkg::QUERY_SPAN);
         end
      end
      else
      begin
         resp_valid <= 1'b1;
         resp_data <= curr_mem[q_idx_r];
         q_idx_r <= q_idx_r + 1'b1;
         q_left_r <= q_left_r - 1'b1;
         if (q_left_r == 5'h01 || q_idx_r + 1'b1 >= current_pointer_query)
         begin
            resp_last <= 1'b1;
            q_busy_r <= 1'b0;
         end
      end
   end

   // error queue posts
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         err_valid <= 1'b0;
         err_code <= list_seq_pkg::ERR_NONE;
      end
      else if (is_cmd && (cmd_code == list_seq_pkg::CMD_QUERY_CURR || cmd_code == list_seq_pkg::CMD_QUERY_CURR_PTR)
               && volt_ptr_r != '0)
      begin
         err_valid <= 1'b1;
         err_code <= list_seq_pkg::ERR_CONFLICT;
      end
      else if (is_cmd && cmd_code == list_seq_pkg::CMD_RUN && st_r == ST_IDLE && relay_point_count_query == '0)
      begin
         err_valid <= 1'b1;
         err_code <= list_seq_pkg::ERR_LEN;
      end
      else
      begin
         err_valid <= 1'b0;
      end
   end
endmodule

// ### tb/host_model.sv
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic clk,
   // command port towards the device
   output logic cmd_valid,
   output list_seq_pkg::cmd_e cmd_code,
   output logic [15:0] cmd_data
);
   // idle bus at time zero
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = list_seq_pkg::CMD_NOP;
      cmd_data = 16'h0000;
   end
   // one value per command, so long tables go over many commands
   task automatic send(input list_seq_pkg::cmd_e code, input logic [15:0] data);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      cmd_data <= data;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_data <= ~data;
   endtask
endmodule

// ### tb/list_seq_chk.sv
`timescale 1ns/1ps
module list_seq_chk #(
   parameter int unsigned DEPTH = 250
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command port
   input wire logic cmd_valid,
   input wire list_seq_pkg::cmd_e cmd_code,
   input wire logic [15:0] cmd_data,
   // state seen at the outputs
   input wire logic running,
   input wire logic dir_up,
   input wire logic [15:0] repetition_count,
   input wire logic [7:0] preamble_skip_steps,
   input wire logic [7:0] current_pointer_query,
   input wire logic [7:0] relay_point_count_query,
   input wire logic err_valid,
   input wire logic [9:0] err_code
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // command decode
   wire logic c_clr = cmd_valid && cmd_code == list_seq_pkg::CMD_CLEAR;
   wire logic c_cur = cmd_valid && cmd_code == list_seq_pkg::CMD_CURR_APPEND;
   wire logic c_dir = cmd_valid && cmd_code == list_seq_pkg::CMD_SET_DIR;
   wire logic c_cnt = cmd_valid && cmd_code == list_seq_pkg::CMD_SET_COUNT;
   wire logic c_skp = cmd_valid && cmd_code == list_seq_pkg::CMD_SET_SKIP;
   wire logic c_run = cmd_valid && cmd_code == list_seq_pkg::CMD_RUN;
   wire logic c_fix = cmd_valid && cmd_code == list_seq_pkg::CMD_FIXED;
   wire logic c_vol = cmd_valid && cmd_code == list_seq_pkg::CMD_VOLT_APPEND && !running;
   // direction bit of the argument, kept as a plain signal for $past
   wire logic dir_bit = cmd_data[0];
   wire logic c_qry = cmd_valid && (cmd_code == list_seq_pkg::CMD_QUERY_CURR
      || cmd_code == list_seq_pkg::CMD_QUERY_CURR_PTR);
   // voltage entries present since the last erase
   logic volt_r;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         volt_r <= 1'b0;
      else if (c_clr)
         volt_r <= 1'b0;
      else if (c_vol)
         volt_r <= 1'b1;
   end
   property p_clear;
      c_clr |=> current_pointer_query == 8'h00 && relay_point_count_query == 8'h00
         && dir_up && preamble_skip_steps == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("erase left state behind");
   property p_append;
      c_cur && !running && current_pointer_query < DEPTH
         |=> current_pointer_query == $past(current_pointer_query) + 8'h01;
   endproperty
   a_append: assert property (p_append) else $error("pointer did not step");
   property p_full;
      c_cur && current_pointer_query >= DEPTH |=> $stable(current_pointer_query);
   endproperty
   a_full: assert property (p_full) else $error("append past full table");
   property p_dir;
      c_dir |=> dir_up == $past(dir_bit);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not stored");
   property p_count;
      c_cnt |=> repetition_count == $past(cmd_data);
   endproperty
   a_count: assert property (p_count) else $error("count not stored");
   property p_skip;
      c_skp && cmd_data <= 16'h00FA |=> {8'h00, preamble_skip_steps} == $past(cmd_data);
   endproperty
   a_skip: assert property (p_skip) else $error("skip not stored");
   property p_norelay;
      c_run && !running && relay_point_count_query == 8'h00
         |=> !running ##[0:1] (err_valid && err_code == list_seq_pkg::ERR_LEN);
   endproperty
   a_norelay: assert property (p_norelay) else $error("run without relay points");
   property p_conflict;
      c_qry && volt_r |=> err_valid && err_code == list_seq_pkg::ERR_CONFLICT;
   endproperty
   a_conflict: assert property (p_conflict) else $error("no conflict error");
   property p_fixed;
      running && c_fix |=> !running;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed mode did not stop");
endmodule

bind output_list_sequencer list_seq_chk #(.DEPTH(DEPTH)) i_chk (.clk(clk), .rst(rst),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .running(running),
   .dir_up(dir_up), .repetition_count(repetition_count), .preamble_skip_steps(preamble_skip_steps),
   .current_pointer_query(current_pointer_query), .relay_point_count_query(relay_point_count_query),
   .err_valid(err_valid), .err_code(err_code));

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic trigger = 1'b0;
   logic relay_assign_list = 1'b0;
   logic cmd_valid, relay_on, running, cont_enable, wait_trigger, dir_up;
   logic resp_valid, resp_last, err_valid;
   list_seq_pkg::cmd_e cmd_code;
   logic [15:0] cmd_data, setpoint, repetition_count, resp_data;
   logic [7:0] preamble_skip_steps, current_pointer_query, relay_point_count_query, query_start_location;
   logic [9:0] err_code;
   logic [15:0] seq_q[$];
   logic rel_q[$];
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   // device with a short dwell tick
   output_list_sequencer #(.TICK_CYCLES(4)) i_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_data(cmd_data), .trigger(trigger), .relay_assign_list(relay_assign_list),
      .setpoint(setpoint), .relay_on(relay_on), .running(running), .cont_enable(cont_enable),
      .wait_trigger(wait_trigger), .dir_up(dir_up), .repetition_count(repetition_count),
      .preamble_skip_steps(preamble_skip_steps), .current_pointer_query(current_pointer_query),
      .relay_point_count_query(relay_point_count_query), .query_start_location(query_start_location),
      .resp_valid(resp_valid), .resp_last(resp_last), .resp_data(resp_data), .err_valid(err_valid),
      .err_code(err_code));
   host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data));
   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // command, then let its edge settle
   task automatic put(input list_seq_pkg::cmd_e c, input logic [15:0] d);
      i_host.send(c, d);
      #1;
   endtask
   // run the list, record each step and the run length
   task automatic run_cap(output int n);
      seq_q = {};
      rel_q = {};
      put(list_seq_pkg::CMD_RUN, 16'h0000);
      @(posedge clk) #1;
      n = 0;
      while (running === 1'b1 && n < 2000)
      begin
         if (seq_q.size() == 0 || seq_q[$] !== setpoint)
         begin
            seq_q.push_back(setpoint);
            rel_q.push_back(relay_on);
         end
         n++;
         @(posedge clk) #1;
      end
   endtask
   // two passes over three steps, skip one when ascending
   task automatic t_run(input bit up);
      int n, k, idx;
      put(list_seq_pkg::CMD_SET_DIR, {15'h0000, up});
      put(list_seq_pkg::CMD_SET_COUNT, 16'h0002);
      run_cap(n);
      chk("steps", seq_q.size(), up ? 5 : 6);
      // two ticks of four cycles per step, plus load and tick latency
      chk("dwell", n >= (up ? 40 : 48) && n <= (up ? 50 : 60), 1);
      for (k = 0; k < seq_q.size(); k++)
      begin
         idx = up ? (k < 3 ? k : k - 2) : 2 - k % 3;
         chk("setpoint", seq_q[k], 16'h0100 + idx);
         chk("relay", rel_q[k], idx != 1);
      end
      chk("idle", running, 0);
      chk("kept", current_pointer_query, 3);
   endtask
   task automatic t_list;
      int i;
      put(list_seq_pkg::CMD_CLEAR, 16'h0000);
      put(list_seq_pkg::CMD_CURR_APPEND, 16'h0100);
      put(list_seq_pkg::CMD_RUN, 16'h0000);
      repeat (2) @(posedge clk);
      #1;
      chk("err", err_code, list_seq_pkg::ERR_LEN);
      chk("norun", running, 0);
      for (i = 1; i < 3; i++)
         put(list_seq_pkg::CMD_CURR_APPEND, 16'h0100 + i);
      for (i = 0; i < 3; i++)
         put(list_seq_pkg::CMD_RELAY_APPEND, i != 1);
      put(list_seq_pkg::CMD_DWELL_APPEND, 16'h0002);
      put(list_seq_pkg::CMD_SET_SKIP, 16'h0001);
      @(posedge clk) relay_assign_list <= 1'b1;
      chk("ptr", current_pointer_query, 3);
      chk("rpts", relay_point_count_query, 3);
      t_run(1'b1);
      t_run(1'b0);
   endtask
   // endless run on one entry, stopped by fixed mode
   task automatic t_single;
      put(list_seq_pkg::CMD_CLEAR, 16'h0000);
      put(list_seq_pkg::CMD_CURR_APPEND, 16'h0555);
      put(list_seq_pkg::CMD_DWELL_APPEND, 16'h0001);
      put(list_seq_pkg::CMD_RELAY_APPEND, 16'h0001);
      put(list_seq_pkg::CMD_SET_COUNT, 16'h0000);
      put(list_seq_pkg::CMD_RUN, 16'h0000);
      repeat (60) @(posedge clk);
      #1;
      chk("endless", running, 1);
      chk("single", setpoint, 16'h0555);
      chk("relay", relay_on, 1);
      put(list_seq_pkg::CMD_FIXED, 16'h0000);
      chk("stop", running, 0);
   endtask
   // query stream, then conflict error
   task automatic t_query;
      int i, n;
      put(list_seq_pkg::CMD_CLEAR, 16'h0000);
      for (i = 0; i < 20; i++)
         put(list_seq_pkg::CMD_CURR_APPEND, 16'h0A00 + i);
      put(list_seq_pkg::CMD_SET_QSTART, 16'h0002);
      chk("qstart", query_start_location, 2);
      put(list_seq_pkg::CMD_QUERY_CURR, 16'h0000);
      n = 0;
      repeat (24)
      begin
         @(posedge clk) #1;
         if (resp_valid === 1'b1)
         begin
            chk("resp", resp_data, 16'h0A02 + n);
            n++;
            chk("last", resp_last, n == 16);
         end
      end
      chk("count", n, 16);
      put(list_seq_pkg::CMD_VOLT_APPEND, 16'h0001);
      put(list_seq_pkg::CMD_QUERY_CURR_PTR, 16'h0000);
      chk("errv", err_valid, 1);
      chk("errc", err_code, list_seq_pkg::ERR_CONFLICT);
      put(list_seq_pkg::CMD_CLEAR, 16'h0000);
      repeat (251) put(list_seq_pkg::CMD_CURR_APPEND, 16'h0001);
      chk("full", current_pointer_query, 16'h00FA);
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("ptr0", current_pointer_query, 0);
      chk("dir0", dir_up, 1);
      chk("cont0", cont_enable, 0);
      chk("cnt0", repetition_count, list_seq_pkg::COUNT_RST);
      chk("rel0", relay_on, 0);
      put(list_seq_pkg::CMD_SET_COUNT, 16'hFFFF);
      chk("cnt", repetition_count, 16'hFFFF);
      put(list_seq_pkg::CMD_SET_SKIP, 16'h00FA);
      put(list_seq_pkg::CMD_SET_SKIP, 16'h00FB);
      chk("skip", preamble_skip_steps, 16'h00FA);
      put(list_seq_pkg::CMD_SET_DIR, 16'h0000);
      chk("down", dir_up, 0);
      put(list_seq_pkg::CMD_CLEAR, 16'h0000);
      chk("up", dir_up, 1);
      chk("skip0", preamble_skip_steps, 0);
      put(list_seq_pkg::CMD_SET_CONT, 16'h0001);
      chk("cont", cont_enable, 1);
      @(posedge clk) trigger <= 1'b1;
      @(posedge clk) trigger <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("rearm", wait_trigger, 1);
      put(list_seq_pkg::CMD_SET_CONT, 16'h0000);
      chk("cont", cont_enable, 0);
      // single trigger now disarms
      @(posedge clk) trigger <= 1'b1;
      @(posedge clk) trigger <= 1'b0;
      #1;
      chk("disarm", wait_trigger, 0);
      t_list();
      t_single();
      t_query();
      report_and_stop();
   end
endmodule
